// ===== hw/ecc_pkg.sv
// Package of constants and types for the EEPROM cycle control block.
package ecc_pkg;
    // ------------------------------------------------------------
    // Control register layout
    // ------------------------------------------------------------
    localparam int FETCH_GO_POS = 0;
    localparam int FETCH_ARM_POS = 1;
    localparam int PROGRAM_GO_POS = 2;
    localparam int PROGRAM_ARM_POS = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [3:0] UPPER_ZERO = 4'h0;
    // ------------------------------------------------------------
    // Cycle timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int READ_NS = 40;
    localparam int READ_CYCLES = (READ_NS * CLK_MHZ + 999) / 1000;
    localparam int WRITE_US = 4000;
    localparam int WRITE_CYCLES = WRITE_US * CLK_MHZ;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    typedef enum logic [1:0] {
        ECC_IDLE,
        ECC_READ,
        ECC_WRITE
    } ecc_state_t;

    // Register write request from the processor side.
    typedef struct packed {
        logic wr;
        logic [7:0] data;
    } ecc_cpu_wr_t;

    // Command to the non-volatile array.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] index;
        logic [7:0] data;
    } ecc_cell_cmd_t;
endpackage

// ===== hw/ecc_top.sv
// EEPROM cycle control register and read/write cycle sequencer.
`timescale 1ns/10ps
module ecc_top
    import ecc_pkg::*;
#(
    parameter int WRITE_TICKS = WRITE_CYCLES,
    parameter int READ_TICKS = READ_CYCLES
) (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire ecc_pkg::ecc_cpu_wr_t CTRL_WR,
    input wire ecc_pkg::ecc_cpu_wr_t BYTE_WR,
    input wire logic [4:0] INDEX_VAL,
    input wire logic [7:0] CELL_RDATA,
    input wire logic DONE_CLR,
    output logic [7:0] CTRL_RDATA,
    output logic [7:0] BYTE_RDATA,
    output ecc_pkg::ecc_cell_cmd_t CELL_CMD,
    output logic DONE_FLAG
);
    import ecc_pkg::*;

    // ------------------------------------------------------------
    // State and timer
    // ------------------------------------------------------------
    ecc_state_t state_reg, state_next;
    logic [31:0] timer_reg, timer_next;
    logic program_arm_bit_reg, fetch_arm_bit_reg;
    logic program_go_reg, fetch_go_reg;
    logic [7:0] cell_byte_reg;
    logic cell_done_flag_reg;
    ecc_cell_cmd_t cmd_reg;

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    wire logic idle = (state_reg == ECC_IDLE);
    wire logic timer_end = (timer_reg == 32'h0000_0000);
    wire logic ctrl_write = CTRL_WR.wr;
    wire logic program_go_req = ctrl_write && CTRL_WR.data[PROGRAM_GO_POS];
    wire logic fetch_go_req = ctrl_write && CTRL_WR.data[FETCH_GO_POS];
    wire logic program_arm_wdata = CTRL_WR.data[PROGRAM_ARM_POS];
    wire logic fetch_arm_wdata = CTRL_WR.data[FETCH_ARM_POS];
    wire logic byte_write = BYTE_WR.wr && idle;
    wire logic in_write = (state_reg == ECC_WRITE);
    wire logic in_read = (state_reg == ECC_READ);

    // A go request counts only with its arm bit already stored, so an arm and
    // go written in one access never start a cycle. The program side wins when
    // both go bits arrive together, and a busy sequencer drops both.
    wire logic start_write = idle && program_go_req
        && program_arm_bit_reg;
    wire logic start_read = idle && fetch_go_req
        && fetch_arm_bit_reg && !start_write;
    wire logic any_start = start_write || start_read;
    wire logic write_end = in_write && timer_end;
    wire logic read_end = in_read && timer_end;
    wire logic [7:0] ctrl_view = {UPPER_ZERO, program_arm_bit_reg, program_go_reg,
        fetch_arm_bit_reg, fetch_go_reg};

    // ------------------------------------------------------------
    // Timer loads
    // ------------------------------------------------------------
    // The counter is loaded with one less than the length so that the end
    // cycle itself is counted; the casts keep the load at the counter width.
    // A length of zero is not supported and would wrap the counter.
    wire logic [31:0] write_load = 32'(WRITE_TICKS - 1);
    wire logic [31:0] read_load = 32'(READ_TICKS - 1);
    wire logic [31:0] timer_dec = timer_reg - 32'h0000_0001;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // A go request that arrives while busy is dropped here, never queued.
    always_comb begin
        state_next = state_reg;
        timer_next = timer_reg;
        case (state_reg)
            ECC_IDLE: begin
                if (start_write) begin
                    state_next = ECC_WRITE;
                    timer_next = write_load;
                end else if (start_read) begin
                    state_next = ECC_READ;
                    timer_next = read_load;
                end
            end
            ECC_READ, ECC_WRITE: begin
                if (timer_end) begin
                    state_next = ECC_IDLE;
                end else begin
                    timer_next = timer_dec;
                end
            end
            default: begin
                state_next = ECC_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg <= ECC_IDLE;
            timer_reg <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            program_arm_bit_reg <= CTRL_RESET[PROGRAM_ARM_POS];
            fetch_arm_bit_reg <= CTRL_RESET[FETCH_ARM_POS];
        end else if (ctrl_write) begin
            // Arm bits take every control write; clearing them disarms at once.
            program_arm_bit_reg <= program_arm_wdata;
            fetch_arm_bit_reg <= fetch_arm_wdata;
        end
    end

    // Go bits are set only by a start and cleared only by the cycle end;
    // software writing zero cannot abort a cycle in flight.
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            program_go_reg <= CTRL_RESET[PROGRAM_GO_POS];
            fetch_go_reg <= CTRL_RESET[FETCH_GO_POS];
        end else begin
            if (start_write) begin
                program_go_reg <= 1'b1;
            end else if (write_end) begin
                program_go_reg <= 1'b0;
            end
            if (start_read) begin
                fetch_go_reg <= 1'b1;
            end else if (read_end) begin
                fetch_go_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Byte register and done flag
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cell_byte_reg <= BYTE_RESET;
        end else if (read_end) begin
            cell_byte_reg <= CELL_RDATA;
        end else if (byte_write) begin
            cell_byte_reg <= BYTE_WR.data;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cell_done_flag_reg <= 1'b0;
        // Set wins over a clear in the same cycle, so a write finish is never lost.
        end else if (write_end) begin
            cell_done_flag_reg <= 1'b1;
        end else if (DONE_CLR) begin
            cell_done_flag_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Array command and outputs
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cmd_reg <= '0;
        end else begin
            cmd_reg.rd <= start_read;
            cmd_reg.wr <= start_write;
            // Index and data are captured only at a start, so the array sees
            // them steady for the whole cycle even if software moves on.
            if (any_start) begin
                cmd_reg.index <= INDEX_VAL;
                cmd_reg.data <= cell_byte_reg;
            end
        end
    end

    // Read views are registered one cycle behind the state they show.
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            CTRL_RDATA <= CTRL_RESET;
        end else begin
            CTRL_RDATA <= ctrl_view;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            BYTE_RDATA <= BYTE_RESET;
        end else begin
            BYTE_RDATA <= cell_byte_reg;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            DONE_FLAG <= 1'b0;
        end else begin
            DONE_FLAG <= cell_done_flag_reg;
        end
    end

    assign CELL_CMD = cmd_reg;
endmodule

// ===== tb/ecc_checker.sv
// Concurrent checks on the EEPROM cycle control ports.
`timescale 1ns/10ps
module ecc_checker
    import ecc_pkg::*;
#(
    parameter int WT = 20,
    parameter int RT = 10
) (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire ecc_pkg::ecc_cpu_wr_t CTRL_WR,
    input wire logic DONE_CLR,
    input wire logic [7:0] CELL_RDATA,
    input wire logic [7:0] CTRL_RDATA,
    input wire logic [7:0] BYTE_RDATA,
    input wire ecc_pkg::ecc_cell_cmd_t CELL_CMD,
    input wire logic DONE_FLAG
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    sequence wr_end;
        ##WT $fell(CTRL_RDATA[2]) && DONE_FLAG;
    endsequence
    upper_zero_a: assert property (CTRL_RDATA[7:4] == 4'h0)
        else $error("upper bits");
    wr_start_a: assert property ($rose(CELL_CMD.wr) |-> $past(CTRL_RDATA[3]) &&
        $past(CTRL_WR.wr && CTRL_WR.data[2]) ##1 CTRL_RDATA[2]) else $error("wr start");
    rd_start_a: assert property ($rose(CELL_CMD.rd) |-> $past(CTRL_RDATA[1]) &&
        $past(CTRL_WR.wr && CTRL_WR.data[0]) ##1 CTRL_RDATA[0]) else $error("rd start");
    wr_end_a: assert property ($rose(CTRL_RDATA[2]) |-> wr_end) else $error("wr end");
    rd_end_a: assert property ($rose(CTRL_RDATA[0]) |-> ##RT $fell(CTRL_RDATA[0]) &&
        BYTE_RDATA == CELL_RDATA) else $error("rd end");
    busy_ignore_a: assert property (CTRL_RDATA[2] && $past(CTRL_RDATA[2]) |->
        !CELL_CMD.wr && !CELL_CMD.rd) else $error("busy start");
    done_hold_a: assert property (DONE_FLAG && !DONE_CLR && !$past(DONE_CLR) |=>
        DONE_FLAG) else $error("done lost");
    arm_reset_a: assert property (disable iff (1'b0) $rose(RST_B) |->
        CTRL_RDATA == 8'h00) else $error("reset view");
endmodule
bind ecc_top ecc_checker #(.WT(WRITE_TICKS), .RT(READ_TICKS)) chk_u (.CORE_CLK(CORE_CLK),
    .RST_B(RST_B), .CTRL_WR(CTRL_WR), .DONE_CLR(DONE_CLR), .CELL_RDATA(CELL_RDATA),
    .CTRL_RDATA(CTRL_RDATA), .BYTE_RDATA(BYTE_RDATA), .CELL_CMD(CELL_CMD), .DONE_FLAG(DONE_FLAG));

// ===== tb/ecc_cell_model.sv
// Behavioural model of the 32 by 8 non-volatile array.
`timescale 1ns/10ps
module ecc_cell_model
    import ecc_pkg::*;
(
    input wire logic clk,
    input wire ecc_pkg::ecc_cell_cmd_t cmd,
    output logic [7:0] rdata = 8'h00
);
    logic [7:0] mem [32];
    int hold = 0;
    // Data is only held for a read; afterwards it toggles so stale samples show up.
    always @(posedge clk) begin
        if (cmd.wr) mem[cmd.index] <= cmd.data;
        if (cmd.rd) begin
            rdata <= mem[cmd.index];
            hold <= 12;
        end else if (hold > 0) hold <= hold - 1;
        else rdata <= ~rdata;
    end
endmodule

// ===== tb/tb_top.sv
// Self-checking testbench for the EEPROM cycle control block.
`timescale 1ns/10ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb_top;
    import ecc_pkg::*;
    logic CORE_CLK = 0, RST_B = 0, DONE_CLR = 0, busy_q = 0;
    ecc_cpu_wr_t CTRL_WR = '0, BYTE_WR = '0;
    logic [4:0] INDEX_VAL = '0;
    logic [7:0] CELL_RDATA, CTRL_RDATA, BYTE_RDATA;
    ecc_cell_cmd_t CELL_CMD;
    logic DONE_FLAG;
    logic [8:0] exp_q[$], e_v;
    logic [31:0] lfsr = 32'h2735_ebe2;
    int n_errors = 0, compares = 0, cyc = 0;
    always #2 CORE_CLK = ~CORE_CLK;
    ecc_top #(.WRITE_TICKS(20)) dut_u (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .CTRL_WR(CTRL_WR),
        .BYTE_WR(BYTE_WR), .INDEX_VAL(INDEX_VAL), .CELL_RDATA(CELL_RDATA), .DONE_CLR(DONE_CLR),
        .CTRL_RDATA(CTRL_RDATA), .BYTE_RDATA(BYTE_RDATA), .CELL_CMD(CELL_CMD),
        .DONE_FLAG(DONE_FLAG));
    ecc_cell_model cell_u (.clk(CORE_CLK), .cmd(CELL_CMD), .rdata(CELL_RDATA));
    task automatic tally_and_finish;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic ctl(input logic [7:0] d);
        @(negedge CORE_CLK);
        CTRL_WR = {1'b1, d};
        @(negedge CORE_CLK);
        CTRL_WR = '0;
        @(negedge CORE_CLK);
    endtask
    // Arm first, go in a later write, then wait for the go bit to drop.
    task automatic run(input logic [7:0] arm, input logic [8:0] e);
        ctl(arm);
        ctl(arm | (arm >> 1));
        exp_q.push_back(e);
        if (arm[3]) begin
            ctl(8'h0A);
            ctl(8'h0B);
            `CHK("busy", 8'h0E, CTRL_RDATA)
        end
        while (CTRL_RDATA[2] | CTRL_RDATA[0]) @(negedge CORE_CLK);
    endtask
    always @(negedge CORE_CLK) begin
        cyc++;
        busy_q <= CTRL_RDATA[2] | CTRL_RDATA[0];
        if (busy_q && !(CTRL_RDATA[2] | CTRL_RDATA[0]) && exp_q.size() > 0) begin
            e_v = exp_q.pop_front();
            `CHK("done_byte", e_v, {DONE_FLAG, BYTE_RDATA})
        end
        if (cyc == 2000) begin
            n_errors++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (3) @(negedge CORE_CLK);
        RST_B = 1;
        ctl(8'h04);
        ctl(8'h01);
        `CHK("no_arm", 8'h00, CTRL_RDATA)
        ctl(8'hF8);
        `CHK("upper", 8'h08, CTRL_RDATA)
        for (int i = 0; i < 3; i++) begin
            lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
            INDEX_VAL = lfsr[4:0];
            BYTE_WR = {1'b1, lfsr[15:8]};
            run(8'h08, {1'b1, lfsr[15:8]});
            BYTE_WR = {1'b1, ~lfsr[15:8]};
            DONE_CLR = 1;
            @(negedge CORE_CLK);
            BYTE_WR = '0;
            DONE_CLR = 0;
            run(8'h02, {1'b0, lfsr[15:8]});
        end
        tally_and_finish;
    end
endmodule
